// ### hdl/rpg_pkg.sv
// package: constants and types of the reference pattern generator
package rpg_pkg;
   localparam int unsigned MEM_AW       = 12;
   localparam int unsigned MEM_DEPTH    = 4096;
   localparam int unsigned FIFO_WIDTH   = 1;
   localparam int unsigned FIFO_DEPTH   = 32;
   localparam int unsigned PRBS_W       = 31;
   localparam int unsigned LEN_W        = 24;
   localparam logic [PRBS_W-1:0] PRBS_SEED = 31'h7FFFFFFF;
   localparam logic [6:0]  DSCR_SEED    = 7'h7F;
   localparam logic [15:0] ROW_W_RST    = 16'h0000;

   typedef enum logic [2:0] {
      RPG_PAT_ZERO  = 3'h1,
      RPG_PAT_DATA  = 3'h2,
      RPG_PAT_MIXED = 3'h4
   } rpg_pat_e;

   typedef enum logic [1:0] {
      RPG_MARK_HALF   = 2'h0,
      RPG_MARK_QUART  = 2'h1,
      RPG_MARK_EIGHTH = 2'h2,
      RPG_MARK_NONE   = 2'h3
   } rpg_mark_e;

   typedef enum logic [3:0] {
      RPG_ST_IDLE = 4'h1,
      RPG_ST_LOAD = 4'h2,
      RPG_ST_RUN  = 4'h4,
      RPG_ST_HOLD = 4'h8
   } rpg_state_e;

   // stage count n encoded 0..7 as 7,9,10,11,15,20,23,31
   function automatic logic [4:0] rpg_stage_n(input logic [2:0] sel);
      case (sel)
         3'h0:    return 5'h07;
         3'h1:    return 5'h09;
         3'h2:    return 5'h0A;
         3'h3:    return 5'h0B;
         3'h4:    return 5'h0F;
         3'h5:    return 5'h14;
         3'h6:    return 5'h17;
         default: return 5'h1F;
      endcase
   endfunction : rpg_stage_n

   // feedback tap of a 2^n-1 generator
   function automatic logic [4:0] rpg_tap(input logic [2:0] sel);
      case (sel)
         3'h0:    return 5'h06;
         3'h1:    return 5'h05;
         3'h2:    return 5'h07;
         3'h3:    return 5'h09;
         3'h4:    return 5'h0E;
         3'h5:    return 5'h11;
         3'h6:    return 5'h12;
         default: return 5'h1C;
      endcase
   endfunction : rpg_tap
endpackage : rpg_pkg

// ### hdl/rpg_stream_if.sv
// interface: valid/ready bit stream between generator and fifo
`timescale 1ns/10ps
interface rpg_stream_if;
   logic valid;
   logic ready;
   logic data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : rpg_stream_if

// ### hdl/rpg_fifo.sv
// module: parameterised valid/ready fifo
`timescale 1ns/10ps
module rpg_fifo #(
   parameter int unsigned WIDTH = 1,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic             core_clk_i,
   input  wire logic             srst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;
   logic             in_rdy;
   logic             next_in_rdy;

   always_comb
   begin
      // registered ready equals not-full, so a beat offered with ready high is never lost
      push        = in_valid_i && in_rdy;
      pop         = out_ready_i && (count != '0);
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
      next_in_rdy = (next_count != (AW+1)'(DEPTH));
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
         in_rdy <= 1'b0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
         in_rdy <= next_in_rdy;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (push)
         mem[wr_ptr] <= in_data_i;
   end

   assign in_ready_o  = in_rdy;
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];
endmodule : rpg_fifo

// ### hdl/rpg_gen.sv
// module: reference generator and comparator for zero-run, data and mixed patterns
// Operation
// - zero-run base length 2^n or 2^n-1, n in 7,9,10,11,15,20,23
// - zero-run pattern inverted polarity maps high level to logic zero
// - inserted zeros programmable 1 to 2^n-2 or 2^n-1 in 1-bit steps
// - 2^n length: final bit one, or extra zero for M-sequence; else ignored
// - choosing zero-run or data type starts loading and lights loading flag
// - data and mixed patterns apply the same polarity mapping
// - confirming an edited pattern reloads memory, loading flag held until done
// - mixed blocks of data rows and PRBS; report blocks, row, data, rows
// - mixed PRBS length 2^n-1, n in 7,9,10,11,15,20,23,31
// - mark ratio 1/2,1/4,1/8,0/8, or inverted 1/2,3/4,7/8,8/8
// - shifted copies by 1 or 3 bits ANDed, only for quarter and eighth
// - PRBS7 descrambling of selected areas when enabled, none when disabled
// - never descramble the data area of a block's first row
// - restart mode reseeds PRBS per block; consecutive mode continues
`timescale 1ns/10ps
module rpg_gen (
   input  wire logic                      core_clk_i,
   input  wire logic                      srst_i,
   input  wire logic [2:0]                pat_type_i,
   input  wire logic                      pat_select_i,
   input  wire logic                      pat_confirm_i,
   input  wire logic                      inverted_polarity_i,
   input  wire logic [2:0]                stage_sel_i,
   input  wire logic                      zr_len_pow2_i,
   input  wire logic [rpg_pkg::LEN_W-1:0] zr_zero_count_i,
   input  wire logic                      zr_final_one_i,
   input  wire logic [1:0]                mark_ratio_i,
   input  wire logic                      shift_three_i,
   input  wire logic                      descramble_en_i,
   input  wire logic                      dscr_data_area_i,
   input  wire logic                      dscr_prbs_area_i,
   input  wire logic                      prbs_consecutive_i,
   input  wire logic [15:0]               row_length_i,
   input  wire logic [15:0]               data_length_i,
   input  wire logic [7:0]                rows_per_block_i,
   input  wire logic [15:0]               block_count_i,
   input  wire logic                      mem_wr_i,
   input  wire logic [rpg_pkg::MEM_AW-1:0] mem_addr_i,
   input  wire logic                      mem_bit_i,
   input  wire logic                      mem_last_i,
   input  wire logic                      rx_bit_i,
   input  wire logic                      rx_valid_i,
   output logic                           rx_ready_o,
   output logic                           loading_o,
   output logic                           compare_active_o,
   output logic                           ref_bit_o,
   output logic                           error_o,
   output logic [15:0]                    rep_blocks_o,
   output logic [15:0]                    rep_row_len_o,
   output logic [15:0]                    rep_data_len_o,
   output logic [7:0]                     rep_rows_o
);
   rpg_pkg::rpg_state_e         state;
   rpg_pkg::rpg_state_e         next_state;
   logic                        mem [rpg_pkg::MEM_DEPTH];
   logic [rpg_pkg::PRBS_W-1:0]  prbs;
   logic [rpg_pkg::PRBS_W-1:0]  next_prbs;
   logic [rpg_pkg::LEN_W-1:0]   pos;
   logic [rpg_pkg::LEN_W-1:0]   next_pos;
   logic [15:0]                 col;
   logic [15:0]                 next_col;
   logic [7:0]                  row;
   logic [7:0]                  next_row;
   logic [rpg_pkg::MEM_AW-1:0]  maddr;
   logic [rpg_pkg::MEM_AW-1:0]  next_maddr;
   logic [6:0]                  dscr;
   logic [6:0]                  next_dscr;
   logic [3:0]                  hist;
   logic [3:0]                  next_hist;
   logic                        ref_bit;
   logic                        next_ref_bit;
   logic                        error;
   logic                        next_error;
   logic                        rdy;
   logic                        next_rdy;
   logic [15:0]                 rb;
   logic [15:0]                 rrl;
   logic [15:0]                 rdl;
   logic [7:0]                  rr;
   logic                        f_valid;
   logic                        f_ready;
   logic                        f_data;
   logic                        take;
   logic [4:0]                  n;
   logic [rpg_pkg::LEN_W-1:0]   period;
   logic [rpg_pkg::LEN_W-1:0]   zlim;
   logic                        prbs_out;
   logic                        marked;
   logic                        raw_ref;
   logic                        in_data;
   logic                        dscr_here;
   logic                        rx_eff;

   rpg_stream_if rx_s ();

   assign rx_s.valid = rx_valid_i;
   assign rx_s.data  = rx_bit_i;

   // small elastic store so the receive side sees back-pressure during reloads
   rpg_fifo #(
      .WIDTH (rpg_pkg::FIFO_WIDTH),
      .DEPTH (rpg_pkg::FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i  (core_clk_i),
      .srst_i      (srst_i),
      .in_valid_i  (rx_s.valid),
      .in_ready_o  (rx_s.ready),
      .in_data_i   (rx_s.data),
      .out_valid_o (f_valid),
      .out_ready_i (f_ready),
      .out_data_o  (f_data)
   );

   // hold the stream while memory is loading
   assign f_ready = (state == rpg_pkg::RPG_ST_RUN);
   assign take    = f_valid && f_ready;
   assign n       = rpg_pkg::rpg_stage_n(stage_sel_i);

   always_comb
   begin
      period = (rpg_pkg::LEN_W)'((25'h1 << n) - 25'h1);
      if (pat_type_i == rpg_pkg::RPG_PAT_ZERO && zr_len_pow2_i)
         period = period + 1'b1;
      // clamp zero run to its legal maximum, one below the period
      zlim = zr_zero_count_i;
      if (zlim == '0)
         zlim = (rpg_pkg::LEN_W)'(1);
      if (zlim > period - 24'h1)
         zlim = period - 24'h1;
      // extra zero joins the run so the length stays 2^n
      if (zr_len_pow2_i && !zr_final_one_i)
         zlim = zlim + 24'h1;
   end

   // taps are polynomial exponents, hence the minus one
   assign prbs_out = prbs[n-5'h1] ^ prbs[rpg_pkg::rpg_tap(stage_sel_i) - 5'h1];

   // mark ratio through ANDed shifted copies
   always_comb
   begin
      case (rpg_pkg::rpg_mark_e'(mark_ratio_i))
         rpg_pkg::RPG_MARK_HALF:   marked = hist[0];
         rpg_pkg::RPG_MARK_QUART:  marked = hist[0] & (shift_three_i ? hist[3] : hist[1]);
         rpg_pkg::RPG_MARK_EIGHTH:
            marked = hist[0] & hist[1] & (shift_three_i ? hist[3] : hist[2]);
         rpg_pkg::RPG_MARK_NONE:   marked = 1'b0;
         default:                  marked = hist[0];
      endcase
   end

   always_comb
   begin
      in_data   = (col < data_length_i);
      // selected areas only, never row 0 data
      dscr_here = descramble_en_i &&
                  ((in_data && dscr_data_area_i && row != 8'h00) ||
                   (!in_data && dscr_prbs_area_i));
      rx_eff    = f_data ^ (dscr_here ? (dscr[6] ^ dscr[5]) : 1'b0);
      case (pat_type_i)
         rpg_pkg::RPG_PAT_ZERO:
            // zero run then final one or pure 2^n-1 pattern
            raw_ref = (pos < zlim) ? 1'b0 : 1'b1;
         rpg_pkg::RPG_PAT_DATA:   raw_ref = mem[maddr];
         rpg_pkg::RPG_PAT_MIXED:  raw_ref = in_data ? mem[maddr] : marked;
         default:                 raw_ref = 1'b0;
      endcase
   end

   always_comb
   begin
      next_state   = state;
      next_prbs    = prbs;
      next_pos     = pos;
      next_col     = col;
      next_row     = row;
      next_maddr   = maddr;
      next_dscr    = dscr;
      next_hist    = hist;
      next_ref_bit = ref_bit;
      next_error   = 1'b0;
      next_rdy     = rdy;
      case (state)
         rpg_pkg::RPG_ST_IDLE:
         begin
            if (pat_type_i == rpg_pkg::RPG_PAT_MIXED)
               next_state = rpg_pkg::RPG_ST_HOLD;
         end
         rpg_pkg::RPG_ST_LOAD:
         begin
            next_rdy = 1'b0;
            if (mem_wr_i && mem_last_i)
               next_state = rpg_pkg::RPG_ST_RUN;
         end
         rpg_pkg::RPG_ST_HOLD:
            next_state = rpg_pkg::RPG_ST_RUN;
         rpg_pkg::RPG_ST_RUN:
         begin
            next_rdy = 1'b1;
            if (take)
            begin
               next_ref_bit = raw_ref ^ inverted_polarity_i;
               next_error   = (raw_ref ^ inverted_polarity_i) != rx_eff;
               next_dscr    = {dscr[5:0], f_data};
               next_pos     = (pos + 1'b1 >= period) ? '0 : pos + 1'b1;
               next_maddr   = maddr + 1'b1;
               if (!in_data || pat_type_i != rpg_pkg::RPG_PAT_MIXED)
               begin
                  next_prbs = {prbs[rpg_pkg::PRBS_W-2:0], prbs_out};
                  next_hist = {hist[2:0], prbs_out};
               end
               if (pat_type_i == rpg_pkg::RPG_PAT_DATA && maddr + 1'b1 >=
                   rpg_pkg::MEM_AW'(data_length_i))
                  next_maddr = '0;
               if (pat_type_i == rpg_pkg::RPG_PAT_MIXED)
               begin
                  next_col = col + 16'h1;
                  if (col + 16'h1 >= row_length_i)
                  begin
                     next_col = '0;
                     next_row = row + 8'h1;
                     if (row + 8'h1 >= rows_per_block_i)
                     begin
                        next_row = '0;
                        if (!prbs_consecutive_i)
                           next_prbs = rpg_pkg::PRBS_SEED;
                     end
                  end
                  if (!in_data)
                     next_maddr = maddr;
               end
            end
         end
         default:
            next_state = rpg_pkg::RPG_ST_IDLE;
      endcase
      // non-mixed type selection or confirm restarts the load
      if ((pat_select_i && pat_type_i != rpg_pkg::RPG_PAT_MIXED) || pat_confirm_i)
      begin
         next_state = rpg_pkg::RPG_ST_LOAD;
         next_prbs  = rpg_pkg::PRBS_SEED;
         next_pos   = '0;
         next_col   = '0;
         next_row   = '0;
         next_maddr = '0;
         next_dscr  = rpg_pkg::DSCR_SEED;
         next_rdy   = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         state   <= rpg_pkg::RPG_ST_IDLE;
         prbs    <= rpg_pkg::PRBS_SEED;
         pos     <= '0;
         col     <= '0;
         row     <= '0;
         maddr   <= '0;
         dscr    <= rpg_pkg::DSCR_SEED;
         hist    <= '0;
         ref_bit <= 1'b0;
         error   <= 1'b0;
         rdy     <= 1'b0;
      end
      else
      begin
         state   <= next_state;
         prbs    <= next_prbs;
         pos     <= next_pos;
         col     <= next_col;
         row     <= next_row;
         maddr   <= next_maddr;
         dscr    <= next_dscr;
         hist    <= next_hist;
         ref_bit <= next_ref_bit;
         error   <= next_error;
         rdy     <= next_rdy;
      end
   end

   // pattern memory written only while loading
   always_ff @(posedge core_clk_i)
   begin
      if (mem_wr_i && state == rpg_pkg::RPG_ST_LOAD)
         mem[mem_addr_i] <= mem_bit_i;
   end

   // report of the loaded mixed layout, captured when loading ends
   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         rb  <= rpg_pkg::ROW_W_RST;
         rrl <= rpg_pkg::ROW_W_RST;
         rdl <= rpg_pkg::ROW_W_RST;
         rr  <= 8'h00;
      end
      else if (state == rpg_pkg::RPG_ST_LOAD && mem_wr_i && mem_last_i)
      begin
         rb  <= block_count_i;
         rrl <= row_length_i;
         rdl <= data_length_i;
         rr  <= rows_per_block_i;
      end
   end

   logic loading_q;
   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         loading_q  <= 1'b0;
      end
      else
      begin
         loading_q  <= (next_state == rpg_pkg::RPG_ST_LOAD);
      end
   end

   assign rx_ready_o       = rx_s.ready;
   assign loading_o        = loading_q;
   assign compare_active_o = rdy;
   assign ref_bit_o        = ref_bit;
   assign error_o          = error;
   assign rep_blocks_o     = rb;
   assign rep_row_len_o    = rrl;
   assign rep_data_len_o   = rdl;
   assign rep_rows_o       = rr;
endmodule : rpg_gen

// ### verification/rpg_gen_monitor.sv
// checker: load, compare and report timing of the generator
`timescale 1ns/10ps
module rpg_gen_monitor (
   input wire logic        core_clk_i,
   input wire logic        srst_i,
   input wire logic [2:0]  pat_type_i,
   input wire logic        pat_select_i,
   input wire logic        pat_confirm_i,
   input wire logic [15:0] row_length_i,
   input wire logic [15:0] data_length_i,
   input wire logic [7:0]  rows_per_block_i,
   input wire logic [15:0] block_count_i,
   input wire logic        mem_wr_i,
   input wire logic        mem_last_i,
   input wire logic        rx_ready_o,
   input wire logic        loading_o,
   input wire logic        compare_active_o,
   input wire logic        error_o,
   input wire logic [15:0] rep_blocks_o,
   input wire logic [15:0] rep_row_len_o,
   input wire logic [15:0] rep_data_len_o,
   input wire logic [7:0]  rep_rows_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   logic fin;
   assign fin = loading_o && mem_wr_i && mem_last_i;
   property p_sel_load;
      !loading_o && pat_select_i && (pat_type_i == rpg_pkg::RPG_PAT_ZERO
         || pat_type_i == rpg_pkg::RPG_PAT_DATA) |=> loading_o;
   endproperty
   a_sel_load: assert property (p_sel_load) else $error("select did not start load");
   property p_cfm_load;
      !loading_o && pat_confirm_i |=> loading_o;
   endproperty
   a_cfm_load: assert property (p_cfm_load) else $error("confirm did not start load");
   property p_load_hold;
      loading_o && !fin |=> loading_o;
   endproperty
   a_load_hold: assert property (p_load_hold) else $error("loading dropped early");
   property p_load_end;
      fin |=> !loading_o ##1 compare_active_o;
   endproperty
   a_load_end: assert property (p_load_end) else $error("load end or compare start late");
   property p_no_cmp;
      loading_o |-> !compare_active_o;
   endproperty
   a_no_cmp: assert property (p_no_cmp) else $error("comparing while loading");
   property p_no_err;
      !compare_active_o && !$past(compare_active_o) |-> !error_o;
   endproperty
   a_no_err: assert property (p_no_err) else $error("error while not comparing");
   property p_rep_cap;
      fin |=> rep_blocks_o == $past(block_count_i) && rep_rows_o == $past(rows_per_block_i)
         && rep_row_len_o == $past(row_length_i) && rep_data_len_o == $past(data_length_i);
   endproperty
   a_rep_cap: assert property (p_rep_cap) else $error("report not captured");
   property p_rep_keep;
      !loading_o |=> $stable(rep_blocks_o) && $stable(rep_data_len_o);
   endproperty
   a_rep_keep: assert property (p_rep_keep) else $error("report changed outside load");
   c_fin: cover property (fin);
   c_err: cover property (error_o);
   c_full: cover property (loading_o && !rx_ready_o);
endmodule : rpg_gen_monitor
bind rpg_gen rpg_gen_monitor i_rpg_gen_monitor (.core_clk_i(core_clk_i), .srst_i(srst_i),
   .pat_type_i(pat_type_i), .pat_select_i(pat_select_i), .pat_confirm_i(pat_confirm_i),
   .row_length_i(row_length_i), .data_length_i(data_length_i),
   .rows_per_block_i(rows_per_block_i), .block_count_i(block_count_i), .mem_wr_i(mem_wr_i),
   .mem_last_i(mem_last_i), .rx_ready_o(rx_ready_o), .loading_o(loading_o),
   .compare_active_o(compare_active_o), .error_o(error_o), .rep_blocks_o(rep_blocks_o),
   .rep_row_len_o(rep_row_len_o), .rep_data_len_o(rep_data_len_o), .rep_rows_o(rep_rows_o));

// ### verification/rpg_rx_model.sv
// partner: received bit stream source with valid/ready handshake
`timescale 1ns/10ps
module rpg_rx_model (
   input  wire logic       core_clk_i,
   input  wire logic       srst_i,
   input  wire logic       start_i,
   input  wire logic [7:0] count_i,
   input  wire logic       level_i,
   input  wire logic       ready_i,
   output logic            bit_o,
   output logic            valid_o
);
   logic [7:0] left;
   logic [7:0] next_left;
   logic       next_bit;
   logic       next_valid;
   always_comb
   begin
      next_left  = left;
      next_bit   = bit_o;
      next_valid = valid_o;
      if (start_i)
      begin
         next_left  = count_i;
         next_bit   = level_i;
         next_valid = 1'b1;
      end
      else if (valid_o && ready_i)
      begin
         next_left = left - 8'h01;
         if (left == 8'h01)
         begin
            next_valid = 1'b0;
            next_bit   = ~bit_o;
         end
      end
      // idle line toggles so a stale bit never looks valid
      else if (!valid_o)
         next_bit = ~bit_o;
   end
   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         left    <= 8'h00;
         bit_o   <= 1'b0;
         valid_o <= 1'b0;
      end
      else
      begin
         left    <= next_left;
         bit_o   <= next_bit;
         valid_o <= next_valid;
      end
   end
endmodule : rpg_rx_model

// ### verification/rpg_gen_tb_top.sv
// testbench: load timing, polarity, report and fifo stall of the generator
`timescale 1ns/10ps
module rpg_gen_tb_top;
   logic clk, srst, sel, cfm, pol, pow2, fin1, sh3, den, dda, dpa, cons, wr, mbit, last;
   logic [2:0]  ptype, stage;
   logic [1:0]  mark;
   logic [23:0] zcnt;
   logic [15:0] rowl, datl, blks;
   logic [7:0]  rows, rcnt;
   logic [11:0] addr;
   logic rgo, rlvl, rxb, rxv, rdy, ld, cmp, refb, err;
   logic [15:0] rb, rr, rd;
   logic [7:0]  rn;
   int mismatches, compares, base;
   int errs = 0;
   rpg_gen i_rpg_gen (.core_clk_i(clk), .srst_i(srst), .pat_type_i(ptype), .pat_select_i(sel),
      .pat_confirm_i(cfm), .inverted_polarity_i(pol), .stage_sel_i(stage), .zr_len_pow2_i(pow2),
      .zr_zero_count_i(zcnt), .zr_final_one_i(fin1), .mark_ratio_i(mark), .shift_three_i(sh3),
      .descramble_en_i(den), .dscr_data_area_i(dda), .dscr_prbs_area_i(dpa),
      .prbs_consecutive_i(cons), .row_length_i(rowl), .data_length_i(datl),
      .rows_per_block_i(rows), .block_count_i(blks), .mem_wr_i(wr), .mem_addr_i(addr),
      .mem_bit_i(mbit), .mem_last_i(last), .rx_bit_i(rxb), .rx_valid_i(rxv), .rx_ready_o(rdy),
      .loading_o(ld), .compare_active_o(cmp), .ref_bit_o(refb), .error_o(err),
      .rep_blocks_o(rb), .rep_row_len_o(rr), .rep_data_len_o(rd), .rep_rows_o(rn));
   rpg_rx_model i_rpg_rx_model (.core_clk_i(clk), .srst_i(srst), .start_i(rgo),
      .count_i(rcnt), .level_i(rlvl), .ready_i(rdy), .bit_o(rxb), .valid_o(rxv));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) if (err === 1'b1) errs <= errs + 1;
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   task automatic wrmem(input logic v);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk);
         wr <= 1'b1; addr <= 12'(i); mbit <= v; last <= (i == 7);
      end
      @(posedge clk);
      wr <= 1'b0; last <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("loading_after", 16'(ld), 16'h0000);
   endtask : wrmem
   task automatic start(input logic [2:0] t, input logic viacfm);
      @(posedge clk);
      ptype <= t; sel <= !viacfm; cfm <= viacfm;
      @(posedge clk);
      sel <= 1'b0; cfm <= 1'b0;
      #1;
      chk("loading", 16'(ld), 16'h0001);
      chk("compare_in_load", 16'(cmp), 16'h0000);
   endtask : start
   task automatic rstart(input logic [7:0] n, input logic lvl);
      @(posedge clk);
      rgo <= 1'b1; rcnt <= n; rlvl <= lvl;
      @(posedge clk);
      rgo <= 1'b0;
   endtask : rstart
   task automatic rwait(input int nerr);
      for (int i = 0; i < 800 && rxv !== 1'b0; i++) @(posedge clk);
      // the fifo may still hold a full backlog after the source stops
      repeat (40) @(posedge clk);
      chk("errors", 16'(errs - base), 16'(nerr));
      base = errs;
   endtask : rwait
   initial
   begin
      #(40 * 20000);
      mismatches++;
      test_done();
   end
   initial
   begin
      {sel, cfm, pol, pow2, fin1, sh3, den, dda, dpa, cons, wr, mbit, last, rgo, rlvl} = '0;
      ptype = rpg_pkg::RPG_PAT_DATA; stage = 3'h0; mark = 2'h0; zcnt = 24'h000001;
      rowl = 16'h0010; datl = 16'h0008; rows = 8'h02; blks = 16'h0003; addr = 12'h000;
      rcnt = 8'h00; base = 0; mismatches = 0; compares = 0; srst = 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      // all-ones pattern makes the phase of the reference irrelevant
      start(rpg_pkg::RPG_PAT_DATA, 1'b0); wrmem(1'b1);
      chk("compare_on", 16'(cmp), 16'h0001);
      rstart(8'd20, 1'b1); rwait(0);
      rstart(8'd8, 1'b0); rwait(8);
      wrmem(1'b0); rstart(8'd8, 1'b1); rwait(0);
      $display("test data done");
      @(posedge clk) pol <= 1'b1;
      start(rpg_pkg::RPG_PAT_DATA, 1'b1); wrmem(1'b1);
      rstart(8'd8, 1'b0); rwait(0);
      rstart(8'd8, 1'b1); rwait(8);
      $display("test polarity done");
      @(posedge clk) pol <= 1'b0;
      zcnt <= 24'h000003;
      start(rpg_pkg::RPG_PAT_ZERO, 1'b0); wrmem(1'b1);
      rstart(8'd8, 1'b1); rwait(3);
      chk("ref_bit", 16'(refb), 16'h0001);
      pow2 <= 1'b1;
      start(rpg_pkg::RPG_PAT_ZERO, 1'b0); wrmem(1'b1);
      rstart(8'd8, 1'b1); rwait(4);
      $display("test zero run done");
      for (int k = 0; k < 8; k++)
      begin
         @(posedge clk);
         stage <= 3'(k); mark <= 2'(k); sh3 <= k[0]; den <= k[1]; dda <= k[2]; dpa <= k[0];
         cons <= k[1]; pol <= k[2]; rowl <= 16'h0020 + 16'(k); datl <= 16'h0008 + 16'(k);
         rows <= 8'h01 + 8'(k); blks <= 16'h0100 + 16'(k);
         start(rpg_pkg::RPG_PAT_MIXED, 1'b1); wrmem(1'b1);
         chk("rep_blocks", rb, 16'h0100 + 16'(k));
         chk("rep_row_len", rr, 16'h0020 + 16'(k));
         chk("rep_data_len", rd, 16'h0008 + 16'(k));
         chk("rep_rows", 16'(rn), 16'h0001 + 16'(k));
      end
      @(posedge clk);
      den <= 1'b0; pol <= 1'b0; mark <= 2'h3; datl <= 16'h0000;
      start(rpg_pkg::RPG_PAT_MIXED, 1'b1); wrmem(1'b1);
      rstart(8'd8, 1'b1); rwait(8);
      $display("test mixed done");
      @(posedge clk);
      pol <= 1'b0; datl <= 16'h0008;
      start(rpg_pkg::RPG_PAT_DATA, 1'b1); rstart(8'd40, 1'b1);
      repeat (60) @(posedge clk);
      chk("fifo_full", 16'(rdy), 16'h0000);
      wrmem(1'b1); rwait(0);
      $display("test fifo done");
      test_done();
   end
endmodule : rpg_gen_tb_top
